/* rtl/eth_regs_pkg.sv */
package eth_regs_pkg;
	// ==========================================================
	// Register indices, byte address is four times the index
	localparam int ADDR_W = 12;
	localparam logic [9:0] IDX_RX_CTRL1 = 10'h074;
	localparam logic [9:0] IDX_TX_QCMD = 10'h080;
	localparam logic [9:0] IDX_RX_QCMD = 10'h082;
	localparam logic [9:0] IDX_INT_MASK = 10'h090;
	localparam logic [9:0] IDX_INT_STATUS = 10'h092;
	localparam logic [9:0] IDX_RX_FCT = 10'h09c;
	localparam logic [9:0] IDX_TX_SPACE = 10'h09e;
	localparam logic [9:0] IDX_HASH0 = 10'h0a0;
	localparam logic [9:0] IDX_HASH1 = 10'h0a2;
	localparam logic [9:0] IDX_HASH2 = 10'h0a4;
	localparam logic [9:0] IDX_HASH3 = 10'h0a6;
	// ==========================================================
	// Field positions
	localparam int BIT_RX_READY = 13;
	localparam int BIT_TX_SPACE = 6;
	localparam int BIT_THRESH_MODE = 5;
	localparam int BIT_TX_MONITOR = 1;
	localparam int BIT_ACCEPT_ALL = 4;
	localparam int BIT_ACCEPT_MCAST = 5;
	localparam int BIT_HASH_MODE = 8;
	localparam logic [15:0] INT_IMPL_MASK = 16'h2040;
	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_THRESHOLD = 8'h00;
	localparam logic [7:0] RST_WAITING = 8'h00;
	localparam logic [15:0] RST_SPACE = 16'h0000;
	localparam logic [15:0] RST_HASH = 16'h0000;
	localparam logic [15:0] RST_WORD = 16'h0000;
	// ==========================================================
	// Hash constants
	localparam logic [31:0] CRC_POLY = 32'h04c11db7;
	localparam logic [31:0] CRC_INIT = 32'hffffffff;
	localparam int HASH_W = 6;
	typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ} bus_state_t;
endpackage : eth_regs_pkg

/* rtl/flag_bank.sv */
`timescale 1ns/10ps
module flag_bank #(
	parameter int W = 16
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [W-1:0] set,
	input wire logic [W-1:0] clr,
	output logic [W-1:0] flags
);
	logic [W-1:0] flags_d;
	// ==========================================================
	// Sticky flags, a set in the clearing cycle is kept.
	always_comb begin
		flags_d = (flags & ~clr) | set;
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			flags <= '0;
		end else begin
			flags <= flags_d;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_set_wins;
		(set != '0) |=> ((flags & $past(set)) == $past(set));
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("Set flag was lost.");
	property p_clear_one;
		(clr != '0) && (set == '0) |=> ((flags & $past(clr)) == '0);
	endproperty
	a_clear_one: assert property (p_clear_one) else $error("Flag not cleared by one.");
endmodule : flag_bank

/* rtl/mcast_hash_filter.sv */
`timescale 1ns/10ps
module mcast_hash_filter (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic da_valid,
	input wire logic [47:0] da,
	input wire logic [63:0] table_bits,
	input wire logic hash_mode,
	input wire logic accept_all,
	output logic accept,
	output logic drop,
	output logic [eth_regs_pkg::HASH_W-1:0] index
);
	logic accept_d;
	logic drop_d;
	logic [eth_regs_pkg::HASH_W-1:0] index_d;
	logic mcast;
	// ==========================================================
	// CRC over the address, first octet first, each octet LSB first.
	function automatic logic [eth_regs_pkg::HASH_W-1:0] crc_hash(input logic [47:0] a);
		logic [31:0] crc;
		logic fb;
		crc = eth_regs_pkg::CRC_INIT;
		for (int o = 5; o >= 0; o--) begin
			for (int b = 0; b < 8; b++) begin
				fb = crc[31] ^ a[o*8+b];
				crc = {crc[30:0], 1'b0};
				if (fb) begin
					crc = crc ^ eth_regs_pkg::CRC_POLY;
				end
			end
		end
		return crc[31:32-eth_regs_pkg::HASH_W];
	endfunction : crc_hash
	// ==========================================================
	// Filter decision
	always_comb begin
		mcast = da[40];
		index_d = crc_hash(da);
		accept_d = 1'b0;
		drop_d = 1'b0;
		if (da_valid) begin
			if (!mcast || accept_all || !hash_mode) begin
				accept_d = 1'b1;
			end else if (table_bits[index_d]) begin
				accept_d = 1'b1;
			end else begin
				drop_d = 1'b1;
			end
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			accept <= 1'b0;
			drop <= 1'b0;
			index <= '0;
		end else begin
			accept <= accept_d;
			drop <= drop_d;
			index <= index_d;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_accept_all;
		da_valid && da[40] && accept_all |=> accept && !drop;
	endproperty
	a_accept_all: assert property (p_accept_all) else $error("Multicast dropped while accepting all.");
	property p_hash_decision;
		da_valid && da[40] && hash_mode && !accept_all |=> (drop == !$past(table_bits[crc_hash(da)]));
	endproperty
	a_hash_decision: assert property (p_hash_decision) else $error("Hash decision wrong.");
	property p_no_hash_mode;
		da_valid && !hash_mode |=> !drop;
	endproperty
	a_no_hash_mode: assert property (p_no_hash_mode) else $error("Drop outside hash mode.");
endmodule : mcast_hash_filter

/* rtl/rx_count_tx_space_hash_filter.sv */
// Operation
// - The upper byte shows the queued frame count captured when the receive flag is raised.
// - The lower byte holds a writable frame count threshold that resets to zero.
// - In threshold mode the receive flag is set once queued frames reach the threshold.
// - A writable 16-bit field, reset to zero, holds the requested transmit space in double words.
// - With the space monitor on, flag bit 6 is set once free transmit space meets the request.
// - The hash index is the six top bits of the CRC over the 48-bit destination address.
// - The top two index bits pick the hash word and the low four pick the bit.
// - A set hash bit accepts the multicast frame and a clear one drops it.
// - The hash table is applied only in hash filtering mode.
// - Accept-all or accept-multicast lets every multicast frame through.
// - Each hash word is a 16-bit writable register that resets to zero.
// - Receive flag bit 13 is set when frames become ready or a frame arrives while they are, and cleared by writing one.
// - Transmit space flag bit 6 is cleared by writing one.
`timescale 1ns/10ps
module rx_count_tx_space_hash_filter (
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic HREADYOUT,
	output logic [31:0] HRDATA,
	output logic HRESP,
	input wire logic [7:0] RX_FRAMES_QUEUED,
	input wire logic RX_FRAME_DONE,
	input wire logic [15:0] TX_FREE_DWORDS,
	input wire logic DA_VALID,
	input wire logic [47:0] DA,
	output logic FRAME_ACCEPT,
	output logic FRAME_DROP,
	output logic [5:0] HASH_INDEX,
	output logic IRQ
);
	// ==========================================================
	// Bus slave state
	eth_regs_pkg::bus_state_t state_q, state_d;
	logic [9:0] addr_q, addr_d;
	logic valid_q, valid_d;
	logic ready_d;
	logic [31:0] rdata_d;
	logic [15:0] rd_mux;
	logic wr;
	logic [15:0] wdata;
	logic take;
	// ==========================================================
	// Register state
	logic [7:0] thresh_q, thresh_d;
	logic [7:0] waiting_q, waiting_d;
	logic [15:0] space_q, space_d;
	logic [15:0] hash_q [4];
	logic [15:0] hash_d [4];
	logic [15:0] ctrl1_q, ctrl1_d;
	logic [15:0] txcmd_q, txcmd_d;
	logic [15:0] rxcmd_q, rxcmd_d;
	logic [15:0] mask_q, mask_d;
	logic rx_cond_q, rx_cond;
	logic tx_cond_q, tx_cond;
	logic rx_set, tx_set;
	logic [15:0] status;
	logic [15:0] set_vec, clr_vec;
	logic irq_d;
	logic [63:0] table_bits;

	function automatic logic hit(input logic [9:0] a, input logic [9:0] idx);
		return a == idx;
	endfunction : hit

	// ==========================================================
	// AHB-Lite slave. Reads take one wait state so that the read data
	// come from a register and a write in its data phase is seen.
	always_comb begin
		take = HSEL && HTRANS[1] && HREADY && (state_q != eth_regs_pkg::BUS_READ);
		state_d = eth_regs_pkg::BUS_IDLE;
		addr_d = addr_q;
		valid_d = valid_q;
		ready_d = 1'b1;
		rdata_d = HRDATA;
		case (state_q)
			eth_regs_pkg::BUS_READ: begin
				rdata_d = {16'h0000, rd_mux};
			end
			eth_regs_pkg::BUS_IDLE, eth_regs_pkg::BUS_WRITE: begin
				rdata_d = HRDATA;
			end
			default: begin
				rdata_d = 32'h00000000;
			end
		endcase
		if (take) begin
			addr_d = HADDR[11:2];
			valid_d = (HADDR[31:12] == 20'h00000) && (HADDR[1:0] == 2'h0);
			state_d = HWRITE ? eth_regs_pkg::BUS_WRITE : eth_regs_pkg::BUS_READ;
			ready_d = HWRITE;
		end
	end
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			state_q <= eth_regs_pkg::BUS_IDLE;
			addr_q <= 10'h000;
			valid_q <= 1'b0;
			HREADYOUT <= 1'b1;
			HRDATA <= 32'h00000000;
			HRESP <= 1'b0;
		end else begin
			state_q <= state_d;
			addr_q <= addr_d;
			valid_q <= valid_d;
			HREADYOUT <= ready_d;
			HRDATA <= rdata_d;
			HRESP <= 1'b0;
		end
	end

	// ==========================================================
	// Read multiplexer, unmapped words read as zero.
	always_comb begin
		rd_mux = 16'h0000;
		if (valid_q) begin
			if (hit(addr_q, eth_regs_pkg::IDX_RX_FCT)) begin
				rd_mux = {waiting_q, thresh_q};
			end else if (hit(addr_q, eth_regs_pkg::IDX_TX_SPACE)) begin
				rd_mux = space_q;
			end else if (hit(addr_q, eth_regs_pkg::IDX_HASH0)) begin
				rd_mux = hash_q[0];
			end else if (hit(addr_q, eth_regs_pkg::IDX_HASH1)) begin
				rd_mux = hash_q[1];
			end else if (hit(addr_q, eth_regs_pkg::IDX_HASH2)) begin
				rd_mux = hash_q[2];
			end else if (hit(addr_q, eth_regs_pkg::IDX_HASH3)) begin
				rd_mux = hash_q[3];
			end else if (hit(addr_q, eth_regs_pkg::IDX_INT_STATUS)) begin
				rd_mux = status;
			end else if (hit(addr_q, eth_regs_pkg::IDX_INT_MASK)) begin
				rd_mux = mask_q;
			end else if (hit(addr_q, eth_regs_pkg::IDX_RX_QCMD)) begin
				rd_mux = rxcmd_q;
			end else if (hit(addr_q, eth_regs_pkg::IDX_TX_QCMD)) begin
				rd_mux = txcmd_q;
			end else if (hit(addr_q, eth_regs_pkg::IDX_RX_CTRL1)) begin
				rd_mux = ctrl1_q;
			end
		end
	end

	// ==========================================================
	// Register writes and event detection
	always_comb begin
		wr = (state_q == eth_regs_pkg::BUS_WRITE) && valid_q;
		wdata = HWDATA[15:0];
		thresh_d = thresh_q;
		space_d = space_q;
		ctrl1_d = ctrl1_q;
		txcmd_d = txcmd_q;
		rxcmd_d = rxcmd_q;
		mask_d = mask_q;
		for (int i = 0; i < 4; i++) begin
			hash_d[i] = hash_q[i];
			if (wr && hit(addr_q, eth_regs_pkg::IDX_HASH0 + 10'(2 * i))) begin
				hash_d[i] = wdata;
			end
		end
		if (wr && hit(addr_q, eth_regs_pkg::IDX_RX_FCT)) begin
			thresh_d = wdata[7:0];
		end
		if (wr && hit(addr_q, eth_regs_pkg::IDX_TX_SPACE)) begin
			space_d = wdata;
		end
		if (wr && hit(addr_q, eth_regs_pkg::IDX_RX_CTRL1)) begin
			ctrl1_d = wdata;
		end
		if (wr && hit(addr_q, eth_regs_pkg::IDX_TX_QCMD)) begin
			txcmd_d = wdata;
		end
		if (wr && hit(addr_q, eth_regs_pkg::IDX_RX_QCMD)) begin
			rxcmd_d = wdata;
		end
		if (wr && hit(addr_q, eth_regs_pkg::IDX_INT_MASK)) begin
			mask_d = wdata;
		end
		// A zero threshold in threshold mode would fire at once; software keeps it nonzero.
		if (rxcmd_q[eth_regs_pkg::BIT_THRESH_MODE]) begin
			rx_cond = RX_FRAMES_QUEUED >= thresh_q;
		end else begin
			rx_cond = RX_FRAMES_QUEUED != 8'h00;
		end
		// A frame arriving while the condition already holds sets the flag again, so a cleared flag is not missed.
		rx_set = rx_cond && (!rx_cond_q || RX_FRAME_DONE);
		tx_cond = txcmd_q[eth_regs_pkg::BIT_TX_MONITOR] && (TX_FREE_DWORDS >= space_q);
		tx_set = tx_cond && !tx_cond_q;
		waiting_d = rx_set ? RX_FRAMES_QUEUED : waiting_q;
		set_vec = 16'h0000;
		set_vec[eth_regs_pkg::BIT_RX_READY] = rx_set;
		set_vec[eth_regs_pkg::BIT_TX_SPACE] = tx_set;
		clr_vec = 16'h0000;
		if (wr && hit(addr_q, eth_regs_pkg::IDX_INT_STATUS)) begin
			clr_vec = wdata & eth_regs_pkg::INT_IMPL_MASK;
		end
		irq_d = (status & mask_q) != 16'h0000;
		table_bits = {hash_q[3], hash_q[2], hash_q[1], hash_q[0]};
	end
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			thresh_q <= eth_regs_pkg::RST_THRESHOLD;
			waiting_q <= eth_regs_pkg::RST_WAITING;
			space_q <= eth_regs_pkg::RST_SPACE;
			for (int i = 0; i < 4; i++) begin
				hash_q[i] <= eth_regs_pkg::RST_HASH;
			end
			ctrl1_q <= eth_regs_pkg::RST_WORD;
			txcmd_q <= eth_regs_pkg::RST_WORD;
			rxcmd_q <= eth_regs_pkg::RST_WORD;
			mask_q <= eth_regs_pkg::RST_WORD;
			rx_cond_q <= 1'b0;
			tx_cond_q <= 1'b0;
			IRQ <= 1'b0;
		end else begin
			thresh_q <= thresh_d;
			waiting_q <= waiting_d;
			space_q <= space_d;
			for (int i = 0; i < 4; i++) begin
				hash_q[i] <= hash_d[i];
			end
			ctrl1_q <= ctrl1_d;
			txcmd_q <= txcmd_d;
			rxcmd_q <= rxcmd_d;
			mask_q <= mask_d;
			rx_cond_q <= rx_cond;
			tx_cond_q <= tx_cond;
			IRQ <= irq_d;
		end
	end

	// ==========================================================
	// Sticky interrupt status and hash filter
	flag_bank #(
		.W(16)
	) u_flags (
		.clk(CLK),
		.rst_b(RST_B),
		.set(set_vec),
		.clr(clr_vec),
		.flags(status)
	);
	mcast_hash_filter u_hash (
		.clk(CLK),
		.rst_b(RST_B),
		.da_valid(DA_VALID),
		.da(DA),
		.table_bits(table_bits),
		.hash_mode(ctrl1_q[eth_regs_pkg::BIT_HASH_MODE]),
		.accept_all(ctrl1_q[eth_regs_pkg::BIT_ACCEPT_ALL] || ctrl1_q[eth_regs_pkg::BIT_ACCEPT_MCAST]),
		.accept(FRAME_ACCEPT),
		.drop(FRAME_DROP),
		.index(HASH_INDEX)
	);

	// ==========================================================
	// Checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);
	sequence s_read_taken;
		HSEL && HTRANS[1] && HREADY && !HWRITE && HREADYOUT;
	endsequence
	sequence s_one_wait;
		!HREADYOUT ##1 HREADYOUT;
	endsequence
	property p_read_wait;
		s_read_taken |=> s_one_wait;
	endproperty
	a_read_wait: assert property (p_read_wait) else $error("Read answer not after one wait state.");
	property p_rx_threshold;
		rxcmd_q[eth_regs_pkg::BIT_THRESH_MODE] && (RX_FRAMES_QUEUED >= thresh_q) && !rx_cond_q
			|=> status[eth_regs_pkg::BIT_RX_READY];
	endproperty
	a_rx_threshold: assert property (p_rx_threshold) else $error("Receive flag not set at threshold.");
	property p_count_capture;
		rx_set |=> (waiting_q == $past(RX_FRAMES_QUEUED));
	endproperty
	a_count_capture: assert property (p_count_capture) else $error("Frame count not captured.");
	property p_count_hold;
		!rx_set |=> $stable(waiting_q);
	endproperty
	a_count_hold: assert property (p_count_hold) else $error("Frame count changed without event.");
	property p_thresh_write;
		wr && hit(addr_q, eth_regs_pkg::IDX_RX_FCT) |=> (thresh_q == $past(HWDATA[7:0]));
	endproperty
	a_thresh_write: assert property (p_thresh_write) else $error("Threshold write lost.");
	property p_space_write;
		wr && hit(addr_q, eth_regs_pkg::IDX_TX_SPACE) |=> (space_q == $past(HWDATA[15:0]));
	endproperty
	a_space_write: assert property (p_space_write) else $error("Space request write lost.");
	property p_tx_space;
		txcmd_q[eth_regs_pkg::BIT_TX_MONITOR] && (TX_FREE_DWORDS >= space_q) && !tx_cond_q
			|=> status[eth_regs_pkg::BIT_TX_SPACE];
	endproperty
	a_tx_space: assert property (p_tx_space) else $error("Space flag not set.");
	property p_hash_write;
		wr && hit(addr_q, eth_regs_pkg::IDX_HASH2) |=> (hash_q[2] == $past(HWDATA[15:0]));
	endproperty
	a_hash_write: assert property (p_hash_write) else $error("Hash word write lost.");
	property p_irq_level;
		((status & mask_q) != 16'h0000) |=> IRQ;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("Interrupt not raised.");
	property p_irq_low;
		((status & mask_q) == 16'h0000) |=> !IRQ;
	endproperty
	a_irq_low: assert property (p_irq_low) else $error("Interrupt raised with no unmasked flag.");
	sequence s_write_taken;
		HSEL && HTRANS[1] && HREADY && HWRITE;
	endsequence
	property p_write_no_wait;
		s_write_taken |=> HREADYOUT;
	endproperty
	a_write_no_wait: assert property (p_write_no_wait) else $error("Write data phase stalled.");
	property p_rx_count_mode;
		!rxcmd_q[eth_regs_pkg::BIT_THRESH_MODE] && (RX_FRAMES_QUEUED != 8'h00) && !rx_cond_q
			|=> status[eth_regs_pkg::BIT_RX_READY];
	endproperty
	a_rx_count_mode: assert property (p_rx_count_mode) else $error("Receive flag not set for queued frame.");
	property p_rx_retrigger;
		rxcmd_q[eth_regs_pkg::BIT_THRESH_MODE] && (RX_FRAMES_QUEUED >= thresh_q) && RX_FRAME_DONE
			|=> status[eth_regs_pkg::BIT_RX_READY] && (waiting_q == $past(RX_FRAMES_QUEUED));
	endproperty
	a_rx_retrigger: assert property (p_rx_retrigger) else $error("Arriving frame did not set receive flag.");
	property p_tx_idle;
		!txcmd_q[eth_regs_pkg::BIT_TX_MONITOR] && !status[eth_regs_pkg::BIT_TX_SPACE]
			|=> !status[eth_regs_pkg::BIT_TX_SPACE];
	endproperty
	a_tx_idle: assert property (p_tx_idle) else $error("Space flag set with monitor off.");
	property p_mask_write;
		wr && hit(addr_q, eth_regs_pkg::IDX_INT_MASK) |=> (mask_q == $past(HWDATA[15:0]));
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("Mask write lost.");
	property p_ctrl_write;
		wr && hit(addr_q, eth_regs_pkg::IDX_RX_CTRL1) |=> (ctrl1_q == $past(HWDATA[15:0]));
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("Receive control write lost.");
endmodule : rx_count_tx_space_hash_filter

/* testbench/host_bus_model.sv */
`timescale 1ns/10ps
module host_bus_model (
	input wire logic clk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	// ==========================================================
	// Idle bus
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end

	// ==========================================================
	// Single word transfer
	// Entered just after a rising edge; it returns at the edge that ends the data phase.
	// Waits are unbounded here because the bench watchdog ends a hung run.
	task automatic xfer(input logic wr, input logic [9:0] idx, input logic [15:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {20'h0, idx, 2'h0};
		hwrite <= wr;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {16'h0, wd};
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : xfer
endmodule : host_bus_model

/* testbench/rx_count_tx_space_hash_filter_tb.sv */
`timescale 1ns/10ps
module rx_count_tx_space_hash_filter_tb;
	logic CLK, RST_B, HSEL, HWRITE, HREADYOUT, HRESP, RX_FRAME_DONE, DA_VALID;
	logic FRAME_ACCEPT, FRAME_DROP, IRQ;
	logic [31:0] HADDR, HWDATA, HRDATA;
	logic [1:0] HTRANS;
	logic [2:0] HSIZE;
	logic [7:0] RX_FRAMES_QUEUED;
	logic [15:0] TX_FREE_DWORDS;
	logic [47:0] DA;
	logic [5:0] HASH_INDEX;
	logic [5:0] e;
	logic [47:0] mda;
	int errors = 0;
	int samples_checked = 0;

	rx_count_tx_space_hash_filter rx_count_tx_space_hash_filter_inst (.CLK(CLK), .RST_B(RST_B), .HSEL(HSEL),
		.HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
		.HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP), .RX_FRAMES_QUEUED(RX_FRAMES_QUEUED),
		.RX_FRAME_DONE(RX_FRAME_DONE), .TX_FREE_DWORDS(TX_FREE_DWORDS), .DA_VALID(DA_VALID), .DA(DA),
		.FRAME_ACCEPT(FRAME_ACCEPT), .FRAME_DROP(FRAME_DROP), .HASH_INDEX(HASH_INDEX), .IRQ(IRQ));

	host_bus_model host_bus_model_inst (.clk(CLK), .hready(HREADYOUT), .hrdata(HRDATA), .hsel(HSEL),
		.haddr(HADDR), .htrans(HTRANS), .hwrite(HWRITE), .hsize(HSIZE), .hwdata(HWDATA));

	// ==========================================================
	// Clock, watchdog and verdict
	initial begin
		CLK = 1'b0;
		forever #2 CLK = ~CLK;
	end

	initial begin
		#(5000 * 4);
		errors++;
		finish_test();
	end

	task automatic finish_test();
		$display("checked %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : finish_test

	// ==========================================================
	// Helpers
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		samples_checked++;
		if (g !== x) begin
			errors++;
			$display("unexpected %s expected %h seen %h", n, x, g);
		end
	endtask : chk

	// The interrupt lags its cause by a cycle, so it is looked at settled, two edges on.
	task automatic chk_irq(input string n, input logic x);
		repeat (2) @(posedge CLK);
		#1;
		chk(n, {31'h0, x}, {31'h0, IRQ});
		@(posedge CLK);
	endtask : chk_irq

	task automatic wr(input logic [9:0] i, input logic [15:0] v);
		logic [31:0] d;
		host_bus_model_inst.xfer(1'b1, i, v, d);
	endtask : wr

	task automatic rd(input string n, input logic [9:0] i, input logic [15:0] x);
		logic [31:0] d;
		host_bus_model_inst.xfer(1'b0, i, 16'h0, d);
		chk(n, {16'h0, x}, d);
		chk("hresp", 32'h0, {31'h0, HRESP});
	endtask : rd

	// Reference hash, kept apart from the design's crc_hash so a slip in its loop cannot hide; CRC_INIT and CRC_POLY are shared.
	function automatic logic [5:0] hidx(input logic [47:0] a);
		logic [31:0] c;
		logic b;
		c = eth_regs_pkg::CRC_INIT;
		for (int i = 5; i >= 0; i--) begin
			for (int j = 0; j < 8; j++) begin
				b = c[31] ^ a[i * 8 + j];
				c = {c[30:0], 1'b0};
				if (b) c = c ^ eth_regs_pkg::CRC_POLY;
			end
		end
		return c[31:26];
	endfunction : hidx

	task automatic frame(input logic [47:0] d, input logic acc);
		DA <= d;
		DA_VALID <= 1'b1;
		@(posedge CLK);
		DA_VALID <= 1'b0;
		#1;
		chk("accept", {31'h0, acc}, {31'h0, FRAME_ACCEPT});
		chk("drop", {31'h0, ~acc}, {31'h0, FRAME_DROP});
		chk("index", {26'h0, hidx(d)}, {26'h0, HASH_INDEX});
		@(posedge CLK);
	endtask : frame

	// ==========================================================
	// Tests
	initial begin
		RST_B = 1'b0;
		RX_FRAMES_QUEUED = 8'h00;
		RX_FRAME_DONE = 1'b0;
		TX_FREE_DWORDS = 16'h0000;
		DA_VALID = 1'b0;
		DA = 48'h0;
		mda = 48'h01005e0000fb;
		e = hidx(mda);
		repeat (20) @(posedge CLK);
		RST_B <= 1'b1;
		@(posedge CLK);
		rd("count_reg", eth_regs_pkg::IDX_RX_FCT, 16'h0000);
		rd("space_reg", eth_regs_pkg::IDX_TX_SPACE, 16'h0000);
		rd("status", eth_regs_pkg::IDX_INT_STATUS, 16'h0000);
		for (int k = 0; k < 4; k++) begin
			rd("hash_rst", eth_regs_pkg::IDX_HASH0 + 10'(2 * k), 16'h0000);
			wr(eth_regs_pkg::IDX_HASH0 + 10'(2 * k), 16'(16'h1111 * (k + 1)));
		end
		for (int k = 0; k < 4; k++) begin
			rd("hash_rw", eth_regs_pkg::IDX_HASH0 + 10'(2 * k), 16'(16'h1111 * (k + 1)));
		end
		wr(eth_regs_pkg::IDX_TX_SPACE, 16'hffff);
		rd("space_rw", eth_regs_pkg::IDX_TX_SPACE, 16'hffff);
		wr(10'h094, 16'hbeef);
		rd("unmapped", 10'h094, 16'h0000);
		wr(eth_regs_pkg::IDX_RX_FCT, 16'hff03);
		rd("thresh", eth_regs_pkg::IDX_RX_FCT, 16'h0003);
		// Threshold mode only after a nonzero threshold is in place.
		wr(eth_regs_pkg::IDX_RX_QCMD, 16'h0020);
		wr(eth_regs_pkg::IDX_INT_MASK, 16'h2040);
		RX_FRAMES_QUEUED <= 8'h02;
		rd("below", eth_regs_pkg::IDX_INT_STATUS, 16'h0000);
		RX_FRAMES_QUEUED <= 8'h03;
		rd("count_cap", eth_regs_pkg::IDX_RX_FCT, 16'h0303);
		rd("rx_flag", eth_regs_pkg::IDX_INT_STATUS, 16'h2000);
		chk_irq("irq_on", 1'b1);
		wr(eth_regs_pkg::IDX_INT_MASK, 16'h0040);
		chk_irq("irq_masked", 1'b0);
		wr(eth_regs_pkg::IDX_INT_MASK, 16'h2040);
		wr(eth_regs_pkg::IDX_INT_STATUS, 16'h2000);
		rd("rx_clr", eth_regs_pkg::IDX_INT_STATUS, 16'h0000);
		chk_irq("irq_off", 1'b0);
		RX_FRAMES_QUEUED <= 8'h04;
		RX_FRAME_DONE <= 1'b1;
		@(posedge CLK);
		RX_FRAME_DONE <= 1'b0;
		rd("rx_again", eth_regs_pkg::IDX_INT_STATUS, 16'h2000);
		rd("count_new", eth_regs_pkg::IDX_RX_FCT, 16'h0403);
		wr(eth_regs_pkg::IDX_INT_STATUS, 16'h2000);
		wr(eth_regs_pkg::IDX_TX_SPACE, 16'h0010);
		TX_FREE_DWORDS <= 16'h000f;
		wr(eth_regs_pkg::IDX_TX_QCMD, 16'h0002);
		rd("tx_short", eth_regs_pkg::IDX_INT_STATUS, 16'h0000);
		TX_FREE_DWORDS <= 16'h0010;
		rd("tx_flag", eth_regs_pkg::IDX_INT_STATUS, 16'h0040);
		chk_irq("irq_tx", 1'b1);
		wr(eth_regs_pkg::IDX_INT_STATUS, 16'h0040);
		rd("tx_clr", eth_regs_pkg::IDX_INT_STATUS, 16'h0000);
		// Without threshold mode the flag follows the queue turning non-empty.
		RX_FRAMES_QUEUED <= 8'h00;
		wr(eth_regs_pkg::IDX_RX_QCMD, 16'h0000);
		RX_FRAMES_QUEUED <= 8'h01;
		rd("rx_plain", eth_regs_pkg::IDX_INT_STATUS, 16'h2000);
		rd("count_plain", eth_regs_pkg::IDX_RX_FCT, 16'h0103);
		wr(eth_regs_pkg::IDX_INT_STATUS, 16'h2000);
		for (int k = 0; k < 4; k++) begin
			wr(eth_regs_pkg::IDX_HASH0 + 10'(2 * k), 16'h0000);
		end
		wr(eth_regs_pkg::IDX_RX_CTRL1, 16'h0100);
		frame(mda, 1'b0);
		frame(mda ^ 48'h010000000000, 1'b1);
		wr(eth_regs_pkg::IDX_HASH0 + {7'h0, e[5:4], 1'b0}, 16'h0001 << e[3:0]);
		frame(mda, 1'b1);
		wr(eth_regs_pkg::IDX_HASH0 + {7'h0, e[5:4], 1'b0}, 16'h0000);
		wr(eth_regs_pkg::IDX_RX_CTRL1, 16'h0110);
		frame(mda, 1'b1);
		wr(eth_regs_pkg::IDX_RX_CTRL1, 16'h0120);
		frame(mda, 1'b1);
		wr(eth_regs_pkg::IDX_RX_CTRL1, 16'h0000);
		frame(mda, 1'b1);
		finish_test();
	end
endmodule : rx_count_tx_space_hash_filter_tb
